// ---- verilog/stwp_port.sv ----
// Two-wire serial port, controller or addressed target, with a plain register port.
// Assumes SCL and SDA inputs are synchronous to SYS_CLK; open-drain pads outside.
`timescale 1ns/1ns
`default_nettype none
module stwp_port #(
	parameter int QUARTER0 = stwp_pkg::QUARTER_CYC0
) (
	// Clock and reset.
	input  wire logic       SYS_CLK,
	input  wire logic       RST_B,
	// Register port.
	input  wire logic [1:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output var  logic [7:0] RDATA,
	// Bus pins, split.
	input  wire logic       SCL_IN,
	output var  logic       SCL_OUT,
	output var  logic       SCL_OE,
	input  wire logic       SDA_IN,
	output var  logic       SDA_OUT,
	output var  logic       SDA_OE
);
	logic       rst_meta, rst_n;
	logic       en, evt, role, gca, acken, done, stretch, begin_req, halt_req, gcen;
	logic [3:0] rate;
	logic [6:0] own;
	logic [7:0] buffer, shreg;
	logic [2:0] state;
	logic       scl_d, sda_d, start_seen, stop_seen, scl_rise, scl_fall;
	logic [3:0] bitn;
	logic       rw, tx_arm, ack_phase, ack_drive, data_drive, tx_low;
	logic       set_evt, set_done, clr_done, abort_tx;
	logic       wr_buf, wr_c0, wr_c1;
	// Controller bit engine.
	stwp_pkg::stwp_phase_e phase;
	logic [15:0] qcnt;
	logic [1:0]  quarter;
	logic        tick, mscl, msda, m_send;
	logic [15:0] qlen;

	// A synchronised release avoids a reset ending on different edges in different flops.
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	assign wr_c0  = WR && ADDR == stwp_pkg::ADDR_CTRL0;
	assign wr_c1  = WR && ADDR == stwp_pkg::ADDR_CTRL1;
	assign wr_buf = WR && ADDR == stwp_pkg::ADDR_BUF;

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			en <= 1'b0; acken <= 1'b0; stretch <= 1'b0; rate <= 4'h0;
			own <= 7'h00; gcen <= 1'b0; buffer <= stwp_pkg::RESET_BYTE;
		end else begin
			if (wr_c0) begin
				en    <= WDATA[stwp_pkg::BIT_EN];
				acken <= WDATA[stwp_pkg::BIT_ACKEN];
			end
			if (wr_c1) begin
				stretch <= WDATA[6];
				rate    <= WDATA[3:0];
			end
			if (WR && ADDR == stwp_pkg::ADDR_OWN) begin
				own  <= WDATA[7:1];
				gcen <= WDATA[stwp_pkg::BIT_GCEN];
			end
			if (wr_buf)
				buffer <= WDATA;
			else if (set_evt && !rw_tx_dir())
				buffer <= shreg;
		end
	end

	function automatic logic rw_tx_dir();
		rw_tx_dir = (state == stwp_pkg::ST_TX) || (role && state == stwp_pkg::ST_RX);
	endfunction

	// Event flag: hardware set wins over a software clear in the same cycle.
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			evt <= 1'b0;
		else if (set_evt)
			evt <= 1'b1;
		else if (wr_c0 && !WDATA[stwp_pkg::BIT_EVT])
			evt <= 1'b0;
	end

	assign clr_done = wr_buf || (RD && ADDR == stwp_pkg::ADDR_BUF);
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			done <= 1'b0;
		else if (set_done)
			done <= 1'b1;
		else if (clr_done)
			done <= 1'b0;
	end

	// Bus edge and condition detection.
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= SCL_IN;
			sda_d <= SDA_IN;
		end
	end
	assign scl_rise   = SCL_IN && !scl_d;
	assign scl_fall   = !SCL_IN && scl_d;
	assign start_seen = SCL_IN && scl_d && sda_d && !SDA_IN;
	assign stop_seen  = SCL_IN && scl_d && !sda_d && SDA_IN;

	// Bit counter and shift register: bits 0-7 data, bit 8 acknowledge.
	assign ack_phase = bitn == 4'h8;
	assign m_send    = role && (state == stwp_pkg::ST_ADDR || state == stwp_pkg::ST_RX);
	assign abort_tx  = state == stwp_pkg::ST_TX && !acken;

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= stwp_pkg::ST_IDLE; role <= 1'b0; gca <= 1'b0; rw <= 1'b0;
			bitn <= 4'h0; shreg <= 8'h00; tx_arm <= 1'b0; set_evt <= 1'b0;
			set_done <= 1'b0; ack_drive <= 1'b0; data_drive <= 1'b0;
		end else begin
			set_evt  <= 1'b0;
			set_done <= 1'b0;
			if (wr_buf)
				tx_arm <= 1'b1;
			if (!en) begin
				state <= stwp_pkg::ST_IDLE; role <= 1'b0; ack_drive <= 1'b0; data_drive <= 1'b0;
			end else if (stop_seen) begin
				state <= stwp_pkg::ST_IDLE;
				role <= 1'b0; gca <= 1'b0; ack_drive <= 1'b0; data_drive <= 1'b0;
				set_evt <= !role;
			end else if (start_seen) begin
				state <= stwp_pkg::ST_ADDR;
				bitn <= 4'hF; ack_drive <= 1'b0; data_drive <= 1'b0;
				set_evt <= 1'b1;
				if (role) begin
					tx_arm <= 1'b0;
				end
			end else if (scl_rise && !ack_phase && state != stwp_pkg::ST_IDLE) begin
				shreg <= {shreg[6:0], SDA_IN};
			end else if (scl_rise && ack_phase && state != stwp_pkg::ST_IDLE) begin
				if (rw_tx_dir() || (m_send)) begin
					if (SDA_IN) begin
						state <= stwp_pkg::ST_NACKD;
					end else if (abort_tx) begin
						state <= stwp_pkg::ST_ABORT;
					end else if (role && state == stwp_pkg::ST_ADDR) begin
						state <= rw ? stwp_pkg::ST_TX : stwp_pkg::ST_RX;
						set_evt <= 1'b1;
					end else begin
						set_evt <= 1'b1;
						set_done <= 1'b1;
					end
				end
			end else if (scl_fall && state != stwp_pkg::ST_IDLE) begin
				bitn <= ack_phase ? 4'h0 : bitn + 4'h1;
				data_drive <= 1'b0;
				ack_drive <= 1'b0;
				if (bitn == 4'h7) begin
					if (!role && state == stwp_pkg::ST_ADDR) begin
						rw <= shreg[0];
						if (shreg[7:1] == own && own != stwp_pkg::GENERAL_CALL_ADDR && acken) begin
							ack_drive <= 1'b1;
							state <= shreg[0] ? stwp_pkg::ST_TX : stwp_pkg::ST_RX;
							set_evt <= 1'b1;
							set_done <= shreg[0];
						end else if (gcen && shreg[7:1] == stwp_pkg::GENERAL_CALL_ADDR && !shreg[0]) begin
							ack_drive <= 1'b1;
							gca <= 1'b1;
							state <= stwp_pkg::ST_RX;
							set_evt <= 1'b1;
						end else begin
							state <= stwp_pkg::ST_NOSEL;
						end
					end else if (!role && state == stwp_pkg::ST_RX) begin
						ack_drive <= acken;
						set_evt <= 1'b1;
						set_done <= acken;
						if (!acken)
							state <= stwp_pkg::ST_IDLE;
					end else if (role && state == stwp_pkg::ST_TX) begin
						ack_drive <= acken;
						set_evt <= 1'b1;
						set_done <= acken;
						if (!acken)
							state <= stwp_pkg::ST_NACKD;
					end
				end else if (ack_phase) begin
					if (m_send && role && state == stwp_pkg::ST_ADDR)
						rw <= buffer[0];
					tx_arm <= 1'b0;
					if (rw_tx_dir() || m_send) begin
						shreg <= buffer;
						data_drive <= tx_arm && state != stwp_pkg::ST_NACKD;
					end
				end else if (rw_tx_dir() || m_send) begin
					data_drive <= 1'b1;
				end
			end else if (wr_buf && bitn == 4'h0 && !SCL_IN && (m_send || (!role && state == stwp_pkg::ST_TX))) begin
				// A byte written while the clock is held low must be loaded before the first rise.
				shreg <= WDATA;
				data_drive <= 1'b1;
				if (role && state == stwp_pkg::ST_ADDR)
					rw <= WDATA[0];
			end
			if (phase == stwp_pkg::PH_START && tick && quarter == 2'h3) begin
				role <= 1'b1;
				state <= stwp_pkg::ST_ADDR;
				set_evt <= 1'b1;
				shreg <= buffer;
				bitn <= 4'hF;
			end
		end
	end

	// Rate divider; select codes above 6 are reserved and run at the slowest rate.
	assign qlen = (rate <= 4'(stwp_pkg::RATE_MAX_SEL)) ? 16'(QUARTER0 >> rate) : 16'(QUARTER0);
	assign tick = qcnt == 16'h0000;
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			qcnt <= 16'h0000;
		else if (tick || phase == stwp_pkg::PH_IDLE)
			qcnt <= qlen - 16'h0001;
		else
			qcnt <= qcnt - 16'h0001;
	end

	// Controller line engine: request bits are cleared once the condition is made.
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			phase <= stwp_pkg::PH_IDLE; quarter <= 2'h0; mscl <= 1'b1; msda <= 1'b1;
			begin_req <= 1'b0; halt_req <= 1'b0;
		end else begin
			if (wr_c1) begin
				begin_req <= WDATA[stwp_pkg::BIT_BEGIN];
				halt_req  <= WDATA[stwp_pkg::BIT_HALT];
			end
			if (tick)
				quarter <= quarter + 2'h1;
			case (phase)
				stwp_pkg::PH_IDLE: begin
					quarter <= 2'h0;
					if (en && begin_req && (state == stwp_pkg::ST_IDLE || role))
						phase <= stwp_pkg::PH_START;
				end
				stwp_pkg::PH_START: begin
					if (tick && quarter == 2'h0) begin
						mscl <= 1'b1;
						msda <= 1'b1;
					end else if (tick && quarter == 2'h2) begin
						msda <= 1'b0;
					end else if (tick && quarter == 2'h3) begin
						mscl <= 1'b0;
						begin_req <= 1'b0;
						phase <= stwp_pkg::PH_WAIT;
					end
				end
				stwp_pkg::PH_WAIT: begin
					quarter <= 2'h0;
					if (halt_req && (state == stwp_pkg::ST_NACKD || !tx_arm || bitn == 4'h0))
						phase <= stwp_pkg::PH_STOP;
					else if (begin_req)
						phase <= stwp_pkg::PH_START;
					else if ((tx_arm || state == stwp_pkg::ST_TX) && bitn == 4'h0)
						phase <= stwp_pkg::PH_BIT;
				end
				stwp_pkg::PH_BIT: begin
					if (tick && quarter == 2'h1)
						mscl <= 1'b1;
					else if (tick && quarter == 2'h3) begin
						mscl <= 1'b0;
						if (ack_phase)
							phase <= stwp_pkg::PH_WAIT;
					end
				end
				stwp_pkg::PH_STOP: begin
					if (tick && quarter == 2'h0)
						msda <= 1'b0;
					else if (tick && quarter == 2'h1)
						mscl <= 1'b1;
					else if (tick && quarter == 2'h3) begin
						msda <= 1'b1;
						halt_req <= 1'b0;
						phase <= stwp_pkg::PH_IDLE;
					end
				end
				default: phase <= stwp_pkg::PH_IDLE;
			endcase
		end
	end

	// Pins. Open drain: the enable pulls low; target clock stretching holds SCL after an ack in ST_TX only, until the buffer is written or read.
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			SCL_OUT <= 1'b0; SCL_OE <= 1'b0; SDA_OUT <= 1'b0; SDA_OE <= 1'b0; tx_low <= 1'b0;
		end else begin
			SCL_OUT <= 1'b0;
			SDA_OUT <= 1'b0;
			// Data may only move while SCL is low, since a change with SCL high is a start or stop.
			tx_low  <= SCL_IN ? tx_low : (data_drive && !shreg[7]);
			SCL_OE  <= (role || phase != stwp_pkg::PH_IDLE) ? !mscl : (stretch && done && state == stwp_pkg::ST_TX && !tx_arm);
			SDA_OE  <= ack_drive || tx_low || (phase != stwp_pkg::PH_BIT && !msda);
		end
	end

	// Register read data, one cycle after the strobe.
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			RDATA <= 8'h00;
		else if (RD) begin
			if (ADDR == stwp_pkg::ADDR_CTRL0)
				RDATA <= {en, evt, role, gca, acken, state};
			else if (ADDR == stwp_pkg::ADDR_CTRL1)
				RDATA <= {done, stretch, begin_req, halt_req, rate};
			else if (ADDR == stwp_pkg::ADDR_OWN)
				RDATA <= {own, gcen};
			else
				RDATA <= buffer;
		end else
			RDATA <= 8'h00;
	end

	sequence s_addr_hit;
		en && scl_fall && !role && state == stwp_pkg::ST_ADDR && bitn == 4'h7 && phase == stwp_pkg::PH_IDLE
			&& shreg[7:1] == own && own != stwp_pkg::GENERAL_CALL_ADDR && acken;
	endsequence
	sequence s_ack_low;
		ack_drive ##1 SDA_OE;
	endsequence
	property p_evt_set_wins;
		@(posedge SYS_CLK) disable iff (!rst_n) set_evt |=> evt;
	endproperty
	property p_stop_idle;
		@(posedge SYS_CLK) disable iff (!rst_n) en && stop_seen |=> state == stwp_pkg::ST_IDLE;
	endproperty
	property p_start_addr;
		@(posedge SYS_CLK) disable iff (!rst_n) en && start_seen |=> state == stwp_pkg::ST_ADDR && bitn == 4'hF;
	endproperty
	property p_ctrl_stop_quiet;
		@(posedge SYS_CLK) disable iff (!rst_n) en && role && stop_seen |=> !set_evt;
	endproperty
	property p_nack_rx_idle;
		@(posedge SYS_CLK) disable iff (!rst_n) en && scl_fall && !role && state == stwp_pkg::ST_RX && bitn == 4'h7
			&& !acken && phase == stwp_pkg::PH_IDLE |=> state == stwp_pkg::ST_IDLE && !ack_drive;
	endproperty
	property p_addr_ack;
		@(posedge SYS_CLK) disable iff (!rst_n) s_addr_hit |=> s_ack_low;
	endproperty
	a_evt_set_wins: assert property (p_evt_set_wins)
		else $error("event flag lost a hardware set");
	a_stop_idle: assert property (p_stop_idle)
		else $error("stop did not return to idle");
	a_start_addr: assert property (p_start_addr)
		else $error("start did not enter address state");
	a_ctrl_stop_quiet: assert property (p_ctrl_stop_quiet)
		else $error("controller stop raised the event flag");
	a_nack_rx_idle: assert property (p_nack_rx_idle)
		else $error("refused byte did not return to idle");
	a_addr_ack: assert property (p_addr_ack)
		else $error("matched address was not acknowledged");
endmodule
`default_nettype wire

// ---- verilog/stwp_pkg.sv ----
// Constants shared by the two-wire serial port: register map, fields, states, timing.
// Assumes the host bus is a plain address/strobe port clocked by SYS_CLK.
`default_nettype none
package stwp_pkg;
	// Register indices; the byte address equals the index on this plain port.
	localparam logic [1:0] ADDR_CTRL0 = 2'h0;
	localparam logic [1:0] ADDR_CTRL1 = 2'h1;
	localparam logic [1:0] ADDR_OWN   = 2'h2;
	localparam logic [1:0] ADDR_BUF   = 2'h3;
	// Control register zero fields.
	localparam int BIT_EN    = 7;
	localparam int BIT_EVT   = 6;
	localparam int BIT_ROLE  = 5;
	localparam int BIT_GCA   = 4;
	localparam int BIT_ACKEN = 3;
	// Control register one fields; BIT_GCEN is bit 0 of the own-address register.
	localparam int BIT_DONE  = 7;
	localparam int BIT_BEGIN = 5;
	localparam int BIT_HALT  = 4;
	localparam int BIT_GCEN  = 0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
	// State codes, target and controller.
	localparam logic [2:0] ST_IDLE  = 3'h0;
	localparam logic [2:0] ST_ADDR  = 3'h1;
	localparam logic [2:0] ST_RX    = 3'h2;
	localparam logic [2:0] ST_TX    = 3'h3;
	localparam logic [2:0] ST_NACKD = 3'h4;
	localparam logic [2:0] ST_ABORT = 3'h5;
	localparam logic [2:0] ST_NOSEL = 3'h6;
	// Controller bit rate: fast RC clock divided by 1024 >> select.
	localparam int FAST_RC_MHZ  = 32;
	localparam int SYS_CLK_MHZ  = 125;
	localparam int RATE_MAX_SEL = 6;
	localparam int BASE_DIV     = 1024;
	// One bit takes four quarter phases; quarter length in system cycles at select 0.
	localparam int QUARTER_CYC0 = (BASE_DIV * SYS_CLK_MHZ) / (FAST_RC_MHZ * 4);
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_START,
		PH_BIT,
		PH_STOP,
		PH_WAIT
	} stwp_phase_e;
endpackage
`default_nettype wire

// ---- sim/stwp_far.sv ----
// Behavioural far side of the two-wire bus, acting as controller or as target.
// Assumes open-drain lines with pull-ups, resolved by the bench from every enable.
`timescale 1ns/1ns
`default_nettype none
module stwp_far #(
	parameter int H = 16
) (
	// Clock and bus levels.
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	// Line pull-downs.
	output var  logic scl_oe,
	output var  logic sda_oe
);
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Works from idle or with the clock held low after a byte.
	task automatic start();
		sda_oe <= 1'b0;
		wt(H);
		scl_oe <= 1'b0;
		wt(H);
		sda_oe <= 1'b1;
		wt(H);
		scl_oe <= 1'b1;
		wt(2);
	endtask
	task automatic stop();
		sda_oe <= 1'b1;
		wt(H);
		scl_oe <= 1'b0;
		wt(H);
		sda_oe <= 1'b0;
		wt(H);
	endtask
	// Data moves only two cycles after the clock falls, so no false start or stop.
	task automatic clk_bit(output logic v);
		wt(H);
		scl_oe <= 1'b0;
		wt(H / 2);
		v = sda;
		wt(H / 2);
		scl_oe <= 1'b1;
		wt(2);
	endtask
	task automatic put(input logic [7:0] b, output logic ack);
		logic v;
		for (int i = 7; i >= 0; i--) begin
			sda_oe <= ~b[i];
			clk_bit(v);
		end
		sda_oe <= 1'b0;
		clk_bit(ack);
	endtask
	task automatic get(input logic nack, output logic [7:0] b);
		logic v;
		sda_oe <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(v);
			b[i] = v;
		end
		sda_oe <= ~nack;
		clk_bit(v);
		sda_oe <= 1'b0;
	endtask
	// Target role: sample on the rising clock, answer through the ninth clock.
	task automatic tgt_rx(input logic nack, output logic [7:0] b, output int per);
		time t0;
		for (int i = 7; i >= 0; i--) begin
			@(posedge scl);
			b[i] = sda;
			if (i == 7) t0 = $time;
			if (i == 6) per = int'(($time - t0) / 8);
		end
		@(negedge scl);
		@(posedge clk);
		sda_oe <= ~nack;
		@(negedge scl);
		@(posedge clk);
		sda_oe <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- sim/two_wire_master_slave_port_tb.sv ----
// Self-checking bench for the two-wire port: target and controller flows over the register port.
// Assumes the far-end model shares the open-drain lines, which idle high through pull-ups.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; $display("Error at %0t: got %h want %h", $time, g, e); end end
module two_wire_master_slave_port_tb;
	localparam int Q = 4;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	logic       scl_out, scl_oe, sda_out, sda_oe, f_scl_oe, f_sda_oe;
	wire        scl = (scl_oe ? scl_out : 1'b1) & ~f_scl_oe;
	wire        sda = (sda_oe ? sda_out : 1'b1) & ~f_sda_oe;
	int         err_total = 0;
	int         compares = 0;
	int         cycles = 0;
	int         per;
	logic [7:0] d;
	logic       ack;
	always #4 clk = ~clk;
	stwp_port #(.QUARTER0(Q)) u_stwp_port (.SYS_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
		.SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe));
	stwp_far #(.H(4 * Q)) u_stwp_far (.clk(clk), .scl(scl), .sda(sda), .scl_oe(f_scl_oe), .sda_oe(f_sda_oe));
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask
	// Writing bit 6 as zero also clears the event flag.
	task automatic c0(input logic [7:0] v);
		wr_reg(stwp_pkg::ADDR_CTRL0, v);
	endtask
	task automatic st(input logic [2:0] e);
		rd_reg(stwp_pkg::ADDR_CTRL0, d);
		`CHK(d[2:0], e)
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		u_stwp_far.start();
		st(stwp_pkg::ST_IDLE);
		u_stwp_far.stop();
		wr_reg(stwp_pkg::ADDR_OWN, 8'h55);
		c0(8'h88);
		u_stwp_far.start();
		st(stwp_pkg::ST_ADDR);
		u_stwp_far.put(8'h54, ack);
		`CHK(ack, 1'b0)
		st(stwp_pkg::ST_RX);
		c0(8'h88);
		u_stwp_far.put(8'hA5, ack);
		rd_reg(stwp_pkg::ADDR_CTRL0, d);
		`CHK(d[6], 1'b1)
		c0(8'h88);
		rd_reg(stwp_pkg::ADDR_CTRL0, d);
		`CHK(d[6], 1'b0)
		rd_reg(stwp_pkg::ADDR_BUF, d);
		`CHK(d, 8'hA5)
		u_stwp_far.start();
		st(stwp_pkg::ST_ADDR);
		u_stwp_far.put(8'h00, ack);
		`CHK(ack, 1'b0)
		rd_reg(stwp_pkg::ADDR_CTRL0, d);
		`CHK(d[4], 1'b1)
		`CHK(d[2:0], stwp_pkg::ST_RX)
		c0(8'h80);
		u_stwp_far.put(8'h11, ack);
		`CHK(ack, 1'b1)
		st(stwp_pkg::ST_IDLE);
		u_stwp_far.stop();
		c0(8'h88);
		u_stwp_far.start();
		u_stwp_far.put(8'h40, ack);
		`CHK(ack, 1'b1)
		u_stwp_far.stop();
		u_stwp_far.start();
		u_stwp_far.put(8'h55, ack);
		`CHK(ack, 1'b0)
		st(stwp_pkg::ST_TX);
		wr_reg(stwp_pkg::ADDR_BUF, 8'h3C);
		c0(8'h88);
		u_stwp_far.get(1'b0, d);
		`CHK(d, 8'h3C)
		rd_reg(stwp_pkg::ADDR_CTRL0, d);
		`CHK(d[6], 1'b1)
		wr_reg(stwp_pkg::ADDR_BUF, 8'hC3);
		u_stwp_far.get(1'b1, d);
		`CHK(d, 8'hC3)
		st(stwp_pkg::ST_NACKD);
		u_stwp_far.stop();
		st(stwp_pkg::ST_IDLE);
		u_stwp_far.start();
		u_stwp_far.put(8'h55, ack);
		wr_reg(stwp_pkg::ADDR_BUF, 8'h96);
		c0(8'h80);
		u_stwp_far.get(1'b0, d);
		`CHK(d, 8'h96)
		st(stwp_pkg::ST_ABORT);
		u_stwp_far.stop();
		c0(8'h88);
		wr_reg(stwp_pkg::ADDR_CTRL1, 8'h20);
		@(negedge sda);
		repeat (4 * Q) @(posedge clk);
		rd_reg(stwp_pkg::ADDR_CTRL0, d);
		`CHK(d[6:5], 2'b11)
		`CHK(d[2:0], stwp_pkg::ST_ADDR)
		c0(8'h88);
		fork
			u_stwp_far.tgt_rx(1'b0, d, per);
			wr_reg(stwp_pkg::ADDR_BUF, 8'hA4);
		join
		`CHK(d, 8'hA4)
		`CHK(per, 4 * Q)
		st(stwp_pkg::ST_RX);
		fork
			u_stwp_far.tgt_rx(1'b1, d, per);
			wr_reg(stwp_pkg::ADDR_BUF, 8'h5A);
		join
		`CHK(d, 8'h5A)
		st(stwp_pkg::ST_NACKD);
		c0(8'h88);
		wr_reg(stwp_pkg::ADDR_CTRL1, 8'h10);
		@(posedge sda iff scl === 1'b1);
		repeat (4 * Q) @(posedge clk);
		rd_reg(stwp_pkg::ADDR_CTRL0, d);
		`CHK(d[6], 1'b0)
		`CHK(d[2:0], stwp_pkg::ST_IDLE)
		complete_run();
	end
endmodule
`default_nettype wire
